// ### hw/pss_map.svh
// Constants of the host serial slave: addresses, pointer values.
// Assumes inclusion by bare name; definitions only.
`ifndef PSS_MAP_SVH
`define PSS_MAP_SVH
`define PSS_BASE_ADDR    7'h20
`define PSS_GLOBAL_ADDR  7'h40
`define PSS_ALERT_ADDR   7'h0C
`define PSS_PTR_RESET    8'h00
`define PSS_MEAS_LO      4'h9
`define PSS_MEAS_HI      4'hC
`define PSS_MEAS_PORT_LO 4'h1
`define PSS_MEAS_PORT_HI 4'h4
`endif

// ### hw/pss_pkg.sv
// Types shared by the host serial slave files.
// Assumes pss_map.svh sits beside it.
package pss_pkg;
  // Register access request toward the register file
  typedef struct packed {
    logic       wr;
    logic       rd;
    logic       quad;
    logic [7:0] addr;
    logic [7:0] wdata;
  } pss_req_t;

  typedef enum logic [2:0] {
    PSS_IDLE  = 3'b000,
    PSS_ADDR  = 3'b001,
    PSS_REG   = 3'b010,
    PSS_WDAT  = 3'b011,
    PSS_RDAT  = 3'b100,
    PSS_ACK   = 3'b101,
    PSS_RACK  = 3'b110,
    PSS_SKIP  = 3'b111
  } pss_state_t;
endpackage

// ### hw/pss_slave.sv
// Host-facing serial slave of the power controller: addressing, pointer,
// quads, global and alert response addresses.
// Assumes an external register file that answers reads combinationally
// from rd_data for the presented quad and pointer.
//
// Function
// - Address is 01, straps A4..A1, quad bit
// - Low address bit selects quad zero or one
// - Single read: pointer write, restart, one byte
// - Single write: address, pointer, one data byte
// - Two-byte reads only for measurement registers
// - Measurement low byte first, high second
// - Stop resets pointer to interrupt register
// - Broadcast address treated as own address
// - Alert address answered only while alert asserted
// - Alert byte is own address, low 1
// - Lose arbitration on sensed 0 while sending 1
// - Win releases alert line, loss keeps it
// - After win, ignore alert until events cleared
`timescale 1ns/1ps
`include "pss_map.svh"
module pss_slave
  import pss_pkg::*;
(
  // Clock and reset
  input  wire logic       ref_clk,
  input  wire logic       sys_rst,
  // Serial bus pins
  input  wire logic       scl_in,
  input  wire logic       sda_in,
  output logic            sda_out,
  output logic            sda_oe,
  // Straps A4..A1
  input  wire logic [3:0] addr_strap,
  // Event state from the register file
  input  wire logic       event_pending,
  // Alert pin, open drain
  output logic            alert_line_n_out,
  output logic            alert_line_n_oe,
  // Register file access
  output pss_req_t        reg_req,
  input  wire logic [7:0] rd_data
);
  pss_state_t state_reg, state_next;
  logic [7:0] shift_reg;
  logic [3:0] bit_cnt_reg;
  logic [7:0] ptr_reg;
  logic       quad_reg;
  logic       rd_mode_reg;
  logic       alert_mode_reg;
  logic       two_byte_reg;
  logic       won_reg;
  logic       lost_reg;
  logic       addr_acked_reg;
  logic       sda_oe_reg;
  logic       alert_oe_reg;
  pss_req_t   req_reg;

  logic scl_rise;
  logic scl_fall;
  logic sda_lvl;
  logic start_det;
  logic stop_det;

  // =====================================================
  // Pin conditioning
  pss_sync u_sync (
    .ref_clk   (ref_clk),
    .sys_rst   (sys_rst),
    .scl_in    (scl_in),
    .sda_in    (sda_in),
    .scl_rise  (scl_rise),
    .scl_fall  (scl_fall),
    .sda_lvl   (sda_lvl),
    .start_det (start_det),
    .stop_det  (stop_det)
  );

  // =====================================================
  // Address decode
  wire [6:0] own_base   = `PSS_BASE_ADDR | {2'h0, addr_strap, 1'b0};
  wire [6:0] rx_addr    = shift_reg[7:1];
  wire       rx_rw      = shift_reg[0];
  wire       hit_own    = (rx_addr[6:1] == own_base[6:1]);
  wire       hit_global = (rx_addr == `PSS_GLOBAL_ADDR);
  wire       alert_act  = alert_oe_reg && !won_reg;
  wire       hit_alert  = (rx_addr == `PSS_ALERT_ADDR) && rx_rw && alert_act;
  wire       addr_hit   = hit_own || hit_global || hit_alert;
  wire       hit_quad   = hit_own ? rx_addr[0] : 1'b0;
  wire [7:0] alert_byte = {own_base[6:1], quad_reg, 1'b1};
  // Measurement window: low nibble 9..C in ports 1..4
  wire       ptr_meas   = (ptr_reg[3:0] >= `PSS_MEAS_LO) && (ptr_reg[3:0] <= `PSS_MEAS_HI) &&
                          (ptr_reg[7:4] >= `PSS_MEAS_PORT_LO) && (ptr_reg[7:4] <= `PSS_MEAS_PORT_HI);
  wire [7:0] tx_byte    = alert_mode_reg ? alert_byte : rd_data;
  wire       tx_bit     = tx_byte[3'(7 - bit_cnt_reg[2:0])];
  wire       byte_done  = (bit_cnt_reg == 4'h7);

  // =====================================================
  // Next state on clock edges of the bus
  always_comb begin
    state_next = state_reg;
    case (state_reg)
      PSS_IDLE: begin
        state_next = PSS_IDLE;
      end
      PSS_ADDR: begin
        if (scl_rise && byte_done) state_next = PSS_ACK;
      end
      PSS_REG, PSS_WDAT: begin
        if (scl_rise && byte_done) state_next = PSS_ACK;
      end
      PSS_RDAT: begin
        if (scl_fall && byte_done) state_next = PSS_RACK;
      end
      PSS_ACK: begin
        // Write side: the byte after the address is the pointer, later ones are data
        if (scl_fall) state_next = rd_mode_reg ? PSS_RDAT : (addr_acked_reg ? PSS_REG : PSS_WDAT);
      end
      PSS_RACK, PSS_SKIP: begin
        state_next = state_reg;
      end
      default: begin
        state_next = PSS_IDLE;
      end
    endcase
  end

  // =====================================================
  // Byte engine: shift, acknowledge, pointer and quad
  always_ff @(posedge ref_clk or posedge sys_rst) begin
    if (sys_rst) begin
      state_reg      <= PSS_IDLE;
      shift_reg      <= 8'h00;
      bit_cnt_reg    <= 4'h0;
      ptr_reg        <= `PSS_PTR_RESET;
      quad_reg       <= 1'b0;
      rd_mode_reg    <= 1'b0;
      alert_mode_reg <= 1'b0;
      two_byte_reg   <= 1'b0;
      won_reg        <= 1'b0;
      lost_reg       <= 1'b0;
      sda_oe_reg     <= 1'b0;
      req_reg        <= '0;
      addr_acked_reg <= 1'b0;
    end else begin
      req_reg.wr <= 1'b0;
      req_reg.rd <= 1'b0;
      // Register file always sees the pointer and quad through a register, one clock late
      req_reg.quad <= quad_reg;
      req_reg.addr <= ptr_reg;
      if (!event_pending) begin
        won_reg <= 1'b0;
      end
      if (stop_det) begin
        state_reg      <= PSS_IDLE;
        ptr_reg        <= `PSS_PTR_RESET;
        sda_oe_reg     <= 1'b0;
        alert_mode_reg <= 1'b0;
      end else if (start_det) begin
        state_reg      <= PSS_ADDR;
        bit_cnt_reg    <= 4'h0;
        sda_oe_reg     <= 1'b0;
        alert_mode_reg <= 1'b0;
        lost_reg       <= 1'b0;
      end else begin
        case (state_reg)
          PSS_ADDR, PSS_REG, PSS_WDAT: begin
            if (scl_rise) begin
              shift_reg   <= {shift_reg[6:0], sda_lvl};
              bit_cnt_reg <= bit_cnt_reg + 4'h1;
            end
            if (scl_fall && bit_cnt_reg == 4'h8) begin
              bit_cnt_reg <= 4'h0;
              if (state_reg == PSS_ADDR && !addr_hit) begin
                state_reg <= PSS_SKIP;
              end else begin
                sda_oe_reg <= 1'b1;
                state_reg  <= PSS_ACK;
                addr_acked_reg <= (state_reg == PSS_ADDR);
                if (state_reg == PSS_ADDR) begin
                  rd_mode_reg    <= rx_rw;
                  alert_mode_reg <= hit_alert;
                  if (!hit_alert) quad_reg <= hit_quad;
                end else if (state_reg == PSS_REG) begin
                  ptr_reg <= shift_reg;
                end else begin
                  req_reg <= '{wr: 1'b1, rd: 1'b0, quad: quad_reg, addr: ptr_reg, wdata: shift_reg};
                end
              end
            end
          end
          PSS_ACK: begin
            if (scl_fall) begin
              sda_oe_reg  <= 1'b0;
              bit_cnt_reg <= 4'h0;
              two_byte_reg <= 1'b0;
              if (rd_mode_reg) begin
                state_reg <= PSS_RDAT;
                sda_oe_reg <= ~tx_bit;
              end else begin
                state_reg <= state_next;
              end
            end
          end
          PSS_RDAT: begin
            if (scl_rise) begin
              if (!sda_lvl && tx_bit && alert_mode_reg) begin
                lost_reg  <= 1'b1;
                state_reg <= PSS_SKIP;
              end
            end
            if (scl_fall) begin
              if (byte_done) begin
                sda_oe_reg <= 1'b0;
                state_reg  <= PSS_RACK;
                req_reg.rd <= 1'b1;
                if (alert_mode_reg) won_reg <= 1'b1;
              end else begin
                bit_cnt_reg <= bit_cnt_reg + 4'h1;
                sda_oe_reg  <= ~tx_byte[3'(6 - bit_cnt_reg[2:0])];
              end
            end
          end
          PSS_RACK: begin
            if (scl_rise) begin
              // Master ack continues only for a measurement pair
              if (!sda_lvl && ptr_meas && !two_byte_reg && !alert_mode_reg) begin
                ptr_reg      <= ptr_reg + 8'h01;
                two_byte_reg <= 1'b1;
                bit_cnt_reg  <= 4'h0;
              end else begin
                state_reg <= PSS_SKIP;
              end
            end
            if (scl_fall && two_byte_reg) begin
              state_reg  <= PSS_RDAT;
              sda_oe_reg <= ~rd_data[7];
            end
          end
          default: begin
            sda_oe_reg <= 1'b0;
          end
        endcase
      end
    end
  end

  // =====================================================
  // Alert line: asserted on events, released by a won response
  always_ff @(posedge ref_clk or posedge sys_rst) begin
    if (sys_rst) begin
      alert_oe_reg <= 1'b0;
    end else begin
      alert_oe_reg <= event_pending && !won_reg;
    end
  end

  // Enables and request straight from flops; sda_out and alert_line_n_out tied low
  assign sda_out          = 1'b0;
  assign sda_oe           = sda_oe_reg;
  assign alert_line_n_out = 1'b0;
  assign alert_line_n_oe  = alert_oe_reg;
  assign reg_req          = req_reg;
endmodule

// ### hw/pss_sync.sv
// Two-flop synchroniser and line-event detector for the bus pins.
// Assumes pins are asynchronous to ref_clk; outputs are same-domain.
`timescale 1ns/1ps
module pss_sync
  import pss_pkg::*;
(
  // Clock and reset
  input  wire logic ref_clk,
  input  wire logic sys_rst,
  // Pins
  input  wire logic scl_in,
  input  wire logic sda_in,
  // Conditioned bus events
  output logic      scl_rise,
  output logic      scl_fall,
  output logic      sda_lvl,
  output logic      start_det,
  output logic      stop_det
);
  logic [1:0] scl_meta_reg;
  logic [1:0] sda_meta_reg;
  logic       scl_last_reg;
  logic       sda_last_reg;

  // =====================================================
  // Synchronisers, first stage read only by the second
  always_ff @(posedge ref_clk or posedge sys_rst) begin
    if (sys_rst) begin
      scl_meta_reg <= 2'h3;
      sda_meta_reg <= 2'h3;
      scl_last_reg <= 1'b1;
      sda_last_reg <= 1'b1;
    end else begin
      scl_meta_reg <= {scl_meta_reg[0], scl_in};
      sda_meta_reg <= {sda_meta_reg[0], sda_in};
      scl_last_reg <= scl_meta_reg[1];
      sda_last_reg <= sda_meta_reg[1];
    end
  end

  // Edge and condition decode
  assign sda_lvl   = sda_meta_reg[1];
  assign scl_rise  = scl_meta_reg[1] & ~scl_last_reg;
  assign scl_fall  = ~scl_meta_reg[1] & scl_last_reg;
  assign start_det = scl_meta_reg[1] & scl_last_reg & sda_last_reg & ~sda_meta_reg[1];
  assign stop_det  = scl_meta_reg[1] & scl_last_reg & ~sda_last_reg & sda_meta_reg[1];
endmodule

// ### test/pse_host_serial_slave_tb.sv
// Self-checking bench for the host serial slave.
// Assumes the master model and a combinational register file stub.
`timescale 1ns/1ps
module pse_host_serial_slave_tb import pss_pkg::*;;
  logic       ref_clk, sys_rst, scl, m_low, sda_oe, sda_out, ev, aoe, aout, a;
  logic [3:0] strap;
  logic [7:0] rd_data, d, wd;
  pss_req_t   reg_req;
  pss_req_t   wq[$];
  int         seed, mismatches, comparisons, rdn;
  wire        sda = ~(m_low | (sda_oe & ~sda_out));
  // ========
  // Clock, register stub, write capture
  initial begin
    ref_clk = 1'b0;
    forever #12.5 ref_clk = ~ref_clk;
  end
  assign rd_data = reg_req.addr ^ {reg_req.quad, 7'h35};
  always @(posedge ref_clk) if (reg_req.wr) wq.push_back(reg_req);
  always @(posedge ref_clk) if (reg_req.rd) rdn++;
  pss_host_mdl i_pss_host_mdl (.ref_clk(ref_clk), .sda(sda), .scl(scl), .sda_low(m_low));
  pss_slave i_pss_slave (.ref_clk(ref_clk), .sys_rst(sys_rst), .scl_in(scl), .sda_in(sda),
    .sda_out(sda_out), .sda_oe(sda_oe), .addr_strap(strap), .event_pending(ev),
    .alert_line_n_out(aout), .alert_line_n_oe(aoe), .reg_req(reg_req), .rd_data(rd_data));
  // ========
  // Expected slave byte and comparison
  function automatic logic [7:0] sa(input logic q, rw);
    return {2'b01, strap, q, rw};
  endfunction
  task automatic chk(input logic [18:0] g, e);
    comparisons++;
    if (g !== e) begin
      mismatches++;
      $display("MISMATCH t=%0t got=%h exp=%h", $time, g, e);
    end
  endtask
  // Read n bytes from quad q at pointer p; p below zero uses the reset pointer
  task automatic rd(input logic q, input int p, input int n);
    logic [7:0] e;
    logic       ms;
    int         r0;
    e = 8'h00;
    i_pss_host_mdl.start;
    if (p >= 0) begin
      e = p[7:0];
      i_pss_host_mdl.xfer(sa(q, 0), 8'h00, 1, d, a); chk(a, 1);
      i_pss_host_mdl.xfer(e, 8'h00, 1, d, a); chk(a, 1);
      i_pss_host_mdl.start;
    end
    // Measurement window: low nibble 9..C, ports 1..4
    ms = (e[3:0] >= 4'h9) && (e[3:0] <= 4'hC) && (e[7:4] >= 4'h1) && (e[7:4] <= 4'h4);
    r0 = rdn;
    i_pss_host_mdl.xfer(sa(q, 1), 8'h00, 1, d, a); chk(a, 1);
    for (int k = 0; k < n; k++) begin
      i_pss_host_mdl.xfer(8'hFF, 8'h00, k == n - 1, d, a);
      chk(d, (k > 0 && !ms) ? 8'hFF : (e + k[7:0]) ^ {q, 7'h35});
    end
    i_pss_host_mdl.stop;
    chk(rdn - r0, ms ? n : 1);
  endtask
  // Write one byte at pointer 8'h14 through address byte ab
  task automatic wr(input logic [7:0] ab, input logic q);
    wd = $random(seed);
    i_pss_host_mdl.start;
    i_pss_host_mdl.xfer(ab, 8'h00, 1, d, a); chk(a, 1);
    i_pss_host_mdl.xfer(8'h14, 8'h00, 1, d, a); chk(a, 1);
    i_pss_host_mdl.xfer(wd, 8'h00, 1, d, a); chk(a, 1);
    i_pss_host_mdl.stop;
    chk(wq.pop_front(), {1'b1, 1'b0, q, 8'h14, wd});
  endtask
  // Alert read; lo forces a lost bit
  task automatic ar(input logic [7:0] lo, input logic ea);
    i_pss_host_mdl.start;
    i_pss_host_mdl.xfer(8'h19, 8'h00, 1, d, a); chk(a, ea);
    if (a === 1'b1) i_pss_host_mdl.xfer(8'hFF, lo, 1, d, a);
    i_pss_host_mdl.stop;
  endtask
  task automatic final_report;
    $display("comparisons=%0d mismatches=%0d", comparisons, mismatches);
    if (mismatches == 0 && comparisons > 0)
      $display("*** PASS ***");
    else
      $display("*** FAIL ***");
    $finish;
  endtask
  // ========
  // Main sequence
  initial begin
    seed = 9;
    strap = $random(seed);
    ev = 1'b0;
    sys_rst = 1'b1;
    repeat (4) @(posedge ref_clk);
    #1 sys_rst = 1'b0;
    i_pss_host_mdl.hc(4);
    wr(sa(1, 0), 1);
    rd(0, 8'h05, 1);
    rd(0, 8'h05, 2);
    rd(1, 8'h29, 2);
    rd(0, -1, 1);
    rd(1, -1, 1);
    // Broadcast forces a zero quad bit, so it lands in the first quad
    wr(8'h80, 0);
    i_pss_host_mdl.start;
    i_pss_host_mdl.xfer({2'b01, ~strap, 2'b00}, 8'h00, 1, d, a); chk(a, 0);
    i_pss_host_mdl.stop;
    ar(8'h00, 0);
    ev = 1'b1;
    i_pss_host_mdl.hc(4);
    chk(aoe, 1);
    ar(8'h01, 1); chk(d, sa(0, 0)); chk(aoe, 1);
    ar(8'h00, 1); chk(d, sa(0, 1)); chk(aoe, 0);
    ar(8'h00, 0);
    ev = 1'b0;
    i_pss_host_mdl.hc(4);
    chk(aoe, 0);
    final_report;
  end
endmodule

// ### test/pss_host_mdl.sv
// Serial bus master model: drives SCL, pulls SDA low.
// Assumes the bench resolves the open-drain SDA with a pull-up.
`timescale 1ns/1ps
module pss_host_mdl (
  // Clock
  input wire logic ref_clk,
  // Bus
  input wire logic sda,
  output logic     scl,
  output logic     sda_low
);
  // ========
  // Bus idle at time zero
  initial begin
    scl = 1'b1;
    sda_low = 1'b0;
  end
  // Wait n clocks, then step past the edge
  task automatic hc(input int n);
    repeat (n) @(posedge ref_clk);
    #1;
  endtask
  // Start or repeated start
  task automatic start;
    sda_low = 1'b0;
    hc(5);
    scl = 1'b1;
    hc(5);
    sda_low = 1'b1;
    hc(5);
    scl = 1'b0;
    hc(5);
  endtask
  // One bit out, line sampled mid high
  task automatic bt(input logic o, output logic i);
    sda_low = ~o;
    hc(5);
    scl = 1'b1;
    hc(5);
    i = sda;
    hc(5);
    scl = 1'b0;
    hc(5);
  endtask
  // Byte plus ack slot; lo pulls bits low against the slave
  task automatic xfer(input logic [7:0] o, lo, input logic ak, output logic [7:0] i, output logic ack);
    for (int k = 7; k >= 0; k--)
      bt(o[k] & ~lo[k], i[k]);
    bt(ak, ack);
    ack = ~ack;
  endtask
  // Stop frees the bus
  task automatic stop;
    sda_low = 1'b1;
    hc(5);
    scl = 1'b1;
    hc(5);
    sda_low = 1'b0;
    hc(10);
  endtask
endmodule

// ### test/pss_slave_chk.sv
// Checker for the host serial slave ports.
// Assumes one clock domain and bind onto every pss_slave.
`timescale 1ns/1ps
module pss_slave_chk
  import pss_pkg::*;
(
  // Clock and reset
  input wire logic       ref_clk,
  input wire logic       sys_rst,
  // Bus and straps
  input wire logic       scl_in,
  input wire logic       sda_in,
  input wire logic       sda_out,
  input wire logic       sda_oe,
  input wire logic [3:0] addr_strap,
  // Alert and register side
  input wire logic       event_pending,
  input wire logic       alert_line_n_out,
  input wire logic       alert_line_n_oe,
  input wire pss_req_t   reg_req,
  input wire logic [7:0] rd_data
);
  // ========
  // Properties
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (sys_rst);
  AST_SDA_OD: assert property (sda_out == 1'b0) else $error("sda driven high");
  AST_ALT_OD: assert property (alert_line_n_out == 1'b0) else $error("alert driven high");
  AST_ALT_CLR: assert property (!event_pending [*3] |-> !alert_line_n_oe) else $error("alert held");
  AST_ALT_SET: assert property ($rose(alert_line_n_oe) |-> $past(event_pending)) else $error("alert cause");
  AST_WR_PLS: assert property (reg_req.wr |=> !reg_req.wr) else $error("write not a pulse");
  AST_RW_EXC: assert property (!(reg_req.wr && reg_req.rd)) else $error("read with write");
  AST_WR_ACK: assert property (reg_req.wr |-> ##[0:3] sda_oe) else $error("write not acked");
  AST_OE_SCL: assert property ($changed(sda_oe) |-> !scl_in) else $error("sda moved, scl high");
  // Main scenarios
  cover property (reg_req.wr);
  cover property (reg_req.rd);
  cover property ($fell(alert_line_n_oe));
endmodule

bind pss_slave pss_slave_chk i_pss_slave_chk (
  .ref_clk(ref_clk), .sys_rst(sys_rst), .scl_in(scl_in), .sda_in(sda_in),
  .sda_out(sda_out), .sda_oe(sda_oe), .addr_strap(addr_strap),
  .event_pending(event_pending), .alert_line_n_out(alert_line_n_out),
  .alert_line_n_oe(alert_line_n_oe), .reg_req(reg_req), .rd_data(rd_data)
);
